// ===== rtl/cfpm_monitor.sv
// The Wishbone slave port and the placing of the registers were left to the implementer.
`include "cfpm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cfpm_monitor
   import cfpm_pkg::*;
#(
   parameter int unsigned SEC_CYC = `CFPM_SEC_CYC
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Pump pulse line
   input  wire logic        pulse_i,
   // Linked output channel
   input  wire logic        out_on_i,
   input  wire logic [7:0]  out_pct_i,
   input  wire logic        out_manual_i,
   // Controlled output
   output logic             out_force_off_o,
   output logic             out_force_on_o,
   output logic             out_force_max_o,
   output logic [7:0]       out_max_pct_o,
   // Status
   input  wire logic        range_alarm_i,
   output logic             total_alarm_o,
   output logic             flow_alarm_o,
   output logic             monitor_active_o
);
   import cfpm_pkg::*;

   // ****************************************************
   // Registers
   // ****************************************************
   logic [31:0] ctrl_r, volpp_r, tset_r, delay_r, clrcnt_r;
   logic [31:0] dband_r, reprime_r, smooth_r, loadval_r;
   logic [31:0] now_r, stamp_r, total_r, rate_r;
   logic [31:0] rd_nxt;
   logic        ack_r;
   logic        cmd_reset, cmd_load, bnd_day, bnd_month, bnd_year;
   logic        wr;

   cfpm_pulse_if pif ();

   cfpm_pulse_sync u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pulse_i (pulse_i),
      .ev      (pif.src)
   );

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction

   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;

   // Single-wait-state slave: ack one cycle after strobe, then drop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r    <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         ack_r    <= wb_cyc_i & wb_stb_i & ~ack_r;
         wb_dat_o <= rd_nxt;
      end
   end
   assign wb_ack_o = ack_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r    <= `CFPM_CTRL_RST;
         volpp_r   <= `CFPM_VOLPP_RST;
         tset_r    <= `CFPM_TSET_RST;
         delay_r   <= `CFPM_DELAY_RST;
         clrcnt_r  <= `CFPM_CLRCNT_RST;
         dband_r   <= `CFPM_DBAND_RST;
         reprime_r <= `CFPM_REPRIME_RST;
         smooth_r  <= `CFPM_SMOOTH_RST;
         loadval_r <= 32'h0000_0000;
         now_r     <= 32'h0000_0000;
      end else if (wr) begin
         if (hit(wb_adr_i, `CFPM_CTRL_OFS))
            ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i);
         if (hit(wb_adr_i, `CFPM_VOLPP_OFS))
            volpp_r <= merge(volpp_r, wb_dat_i, wb_sel_i);
         if (hit(wb_adr_i, `CFPM_TSET_OFS))
            tset_r <= merge(tset_r, wb_dat_i, wb_sel_i);
         if (hit(wb_adr_i, `CFPM_DELAY_OFS))
            delay_r <= merge(delay_r, wb_dat_i, wb_sel_i);
         if (hit(wb_adr_i, `CFPM_CLRCNT_OFS))
            clrcnt_r <= merge(clrcnt_r, wb_dat_i, wb_sel_i);
         if (hit(wb_adr_i, `CFPM_DBAND_OFS))
            dband_r <= merge(dband_r, wb_dat_i, wb_sel_i);
         if (hit(wb_adr_i, `CFPM_REPRIME_OFS))
            reprime_r <= merge(reprime_r, wb_dat_i, wb_sel_i);
         if (hit(wb_adr_i, `CFPM_SMOOTH_OFS))
            smooth_r <= merge(smooth_r, wb_dat_i, wb_sel_i);
         if (hit(wb_adr_i, `CFPM_LOADVAL_OFS))
            loadval_r <= merge(loadval_r, wb_dat_i, wb_sel_i);
         if (hit(wb_adr_i, `CFPM_NOW_OFS))
            now_r <= merge(now_r, wb_dat_i, wb_sel_i);
      end
   end

   // Commands are self-clearing strobes, never stored
   always_comb begin
      logic c;
      c = wr & hit(wb_adr_i, `CFPM_CMD_OFS) & wb_sel_i[0];
      cmd_reset = c & wb_dat_i[`CFPM_CMD_RESET];
      cmd_load  = c & wb_dat_i[`CFPM_CMD_LOAD];
      bnd_day   = c & wb_dat_i[`CFPM_CMD_DAY];
      bnd_month = c & wb_dat_i[`CFPM_CMD_MONTH];
      bnd_year  = c & wb_dat_i[`CFPM_CMD_YEAR];
   end

   // ****************************************************
   // Decoded settings
   // ****************************************************
   logic        tmode_off;
   cfpm_fmode_t fmode;
   cfpm_sched_t sched;
   logic        prop, rp_en;
   logic        sched_hit;

   assign tmode_off = ctrl_r[`CFPM_CTRL_TMODE];
   assign fmode = cfpm_fmode_t'(ctrl_r[`CFPM_CTRL_FMODE_LO +: 2]);
   assign sched = cfpm_sched_t'(ctrl_r[`CFPM_CTRL_SCHED_LO +: 2]);
   assign prop  = ctrl_r[`CFPM_CTRL_PROP];
   assign rp_en = ctrl_r[`CFPM_CTRL_REPRIME];
   assign out_max_pct_o = ctrl_r[`CFPM_CTRL_MAXPCT_LO +: 8];

   // Calendar boundaries arrive from the clock keeper as commands
   always_comb begin
      unique case (sched)
         CFPM_SCH_NONE:  sched_hit = 1'b0;
         CFPM_SCH_DAY:   sched_hit = bnd_day;
         CFPM_SCH_MONTH: sched_hit = bnd_month;
         CFPM_SCH_YEAR:  sched_hit = bnd_year;
      endcase
   end

   // ****************************************************
   // Totalizer and rate
   // ****************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         total_r <= 32'h0000_0000;
         stamp_r <= 32'h0000_0000;
      end else if (cmd_reset | sched_hit) begin
         total_r <= 32'h0000_0000;
         stamp_r <= now_r;
      end else if (cmd_load) begin
         total_r <= loadval_r;
      end else if (pif.pulse) begin
         total_r <= total_r + volpp_r;
      end
   end

   assign total_alarm_o = total_r > tset_r;

   // Rate in ml per second: blend = s*old + (100-s)*new, over 100
   logic [63:0] inst_rate;
   logic [63:0] blend;
   always_comb begin
      inst_rate = (pif.period == 32'h0000_0000) ? 64'h0 :
                  (64'(volpp_r) * 64'(SEC_CYC)) / 64'(pif.period);
      blend = (64'(rate_r) * 64'(smooth_r[6:0]) +
               inst_rate * 64'(7'd100 - smooth_r[6:0])) / 64'd100;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rate_r <= 32'h0000_0000;
      end else if (pif.pulse) begin
         rate_r <= blend[31:0];
      end
   end

   // ****************************************************
   // Flow verify
   // ****************************************************
   cfpm_fv_state_t st_r;
   logic [31:0] sec_r;
   logic        tick;
   logic [31:0] idle_r, cnt_r, rp_r;
   logic        out_active;
   logic        fv_clear;

   // Whole-second tick drives the MM:SS timers, held as seconds
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sec_r <= 32'h0000_0000;
      end else if (sec_r >= 32'(SEC_CYC - 1)) begin
         sec_r <= 32'h0000_0000;
      end else begin
         sec_r <= sec_r + 32'h0000_0001;
      end
   end
   assign tick = sec_r >= 32'(SEC_CYC - 1);

   assign out_active = prop ? (32'(out_pct_i) > dband_r) : out_on_i;

   // Seconds since last pulse while the output runs; restarts on pulse, and at each delay period once alarmed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idle_r <= 32'h0000_0000;
      end else if (pif.pulse) begin
         idle_r <= 32'h0000_0000;
      end else if (st_r == CFPM_ST_OK && !out_active) begin
         idle_r <= 32'h0000_0000;
      end else if (tick && idle_r >= delay_r - 32'h1 &&
                   st_r != CFPM_ST_OK) begin
         idle_r <= 32'h0000_0000;
      end else if (tick) begin
         idle_r <= idle_r + 32'h0000_0001;
      end
   end

   assign fv_clear = pif.pulse && (cnt_r + 32'h1 >= clrcnt_r);

   // Clearing pulse count; pulse wins over the period wipe
   always_ff @(posedge clk_i) begin
      if (rst_i || st_r == CFPM_ST_OK) begin
         cnt_r <= 32'h0000_0000;
      end else if (pif.pulse) begin
         cnt_r <= cnt_r + 32'h0000_0001;
      end else if (tick && idle_r >= delay_r - 32'h1) begin
         cnt_r <= 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= CFPM_ST_OK;
         rp_r <= 32'h0000_0000;
      end else begin
         unique case (st_r)
            CFPM_ST_OK: begin
               if (fmode != CFPM_FV_DISABLED && out_active && !pif.pulse &&
                   tick && idle_r >= delay_r - 32'h1) begin
                  rp_r <= reprime_r;
                  st_r <= (rp_en && reprime_r != 32'h0) ?
                          CFPM_ST_REPRIME : CFPM_ST_LOCKED;
               end
            end
            CFPM_ST_REPRIME: begin
               if (fv_clear || fmode == CFPM_FV_DISABLED) begin
                  st_r <= CFPM_ST_OK;
               end else if (tick) begin
                  rp_r <= rp_r - 32'h0000_0001;
                  if (rp_r <= 32'h0000_0001) begin
                     st_r <= CFPM_ST_LOCKED;
                  end
               end
            end
            CFPM_ST_LOCKED: begin
               if (fv_clear || fmode == CFPM_FV_DISABLED) begin
                  st_r <= CFPM_ST_OK;
               end
            end
            default: st_r <= CFPM_ST_OK;
         endcase
      end
   end

   // ****************************************************
   // Output control
   // ****************************************************
   logic rp_run, fv_off, tot_off;
   assign flow_alarm_o = st_r != CFPM_ST_OK;
   assign rp_run  = st_r == CFPM_ST_REPRIME;
   assign fv_off  = (st_r == CFPM_ST_LOCKED) &&
                    (fmode == CFPM_FV_INTERLOCK);
   assign tot_off = total_alarm_o & tmode_off;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_force_off_o <= 1'b0;
         out_force_on_o  <= 1'b0;
         out_force_max_o <= 1'b0;
      end else begin
         out_force_off_o <= tot_off | fv_off;
         out_force_on_o  <= rp_run & ~tot_off;
         out_force_max_o <= rp_run & ~tot_off & prop;
      end
   end

   assign monitor_active_o = flow_alarm_o | total_alarm_o |
                             range_alarm_i;

   // ****************************************************
   // Read mux
   // ****************************************************
   always_comb begin
      unique case (wb_adr_i)
         `CFPM_CTRL_OFS:    rd_nxt = ctrl_r;
         `CFPM_STAT_OFS:    rd_nxt = {26'h0, st_r, monitor_active_o,
                                      flow_alarm_o, total_alarm_o};
         `CFPM_VOLPP_OFS:   rd_nxt = volpp_r;
         `CFPM_TSET_OFS:    rd_nxt = tset_r;
         `CFPM_DELAY_OFS:   rd_nxt = delay_r;
         `CFPM_CLRCNT_OFS:  rd_nxt = clrcnt_r;
         `CFPM_DBAND_OFS:   rd_nxt = dband_r;
         `CFPM_REPRIME_OFS: rd_nxt = reprime_r;
         `CFPM_SMOOTH_OFS:  rd_nxt = smooth_r;
         `CFPM_TOTAL_OFS:   rd_nxt = total_r;
         `CFPM_RATE_OFS:    rd_nxt = rate_r;
         `CFPM_LOADVAL_OFS: rd_nxt = loadval_r;
         `CFPM_STAMP_OFS:   rd_nxt = stamp_r;
         `CFPM_NOW_OFS:     rd_nxt = now_r;
         default:           rd_nxt = 32'h0000_0000;
      endcase
   end
endmodule // cfpm_monitor
`default_nettype wire

// ===== rtl/cfpm_params.svh
`ifndef CFPM_PARAMS_SVH
`define CFPM_PARAMS_SVH
// Register byte offsets
`define CFPM_CTRL_OFS      8'h00
`define CFPM_STAT_OFS      8'h04
`define CFPM_VOLPP_OFS     8'h08
`define CFPM_TSET_OFS      8'h0C
`define CFPM_DELAY_OFS     8'h10
`define CFPM_CLRCNT_OFS    8'h14
`define CFPM_DBAND_OFS     8'h18
`define CFPM_REPRIME_OFS   8'h1C
`define CFPM_SMOOTH_OFS    8'h20
`define CFPM_TOTAL_OFS     8'h24
`define CFPM_RATE_OFS      8'h28
`define CFPM_LOADVAL_OFS   8'h2C
`define CFPM_STAMP_OFS     8'h30
`define CFPM_CMD_OFS       8'h34
`define CFPM_NOW_OFS       8'h38
// Control field positions
`define CFPM_CTRL_TMODE    0
`define CFPM_CTRL_FMODE_LO 1
`define CFPM_CTRL_SCHED_LO 3
`define CFPM_CTRL_PROP     5
`define CFPM_CTRL_REPRIME  6
`define CFPM_CTRL_MAXPCT_LO 8
// Command bits (write one to act)
`define CFPM_CMD_RESET     0
`define CFPM_CMD_LOAD      1
`define CFPM_CMD_DAY       2
`define CFPM_CMD_MONTH     3
`define CFPM_CMD_YEAR      4
// Reset values
`define CFPM_CTRL_RST      32'h0000_6402
`define CFPM_VOLPP_RST     32'h0000_0001
`define CFPM_TSET_RST      32'hFFFF_FFFF
`define CFPM_DELAY_RST     32'h0000_0100
`define CFPM_CLRCNT_RST    32'h0000_0003
`define CFPM_DBAND_RST     32'h0000_0005
`define CFPM_REPRIME_RST   32'h0000_0000
`define CFPM_SMOOTH_RST    32'h0000_000A
// Timing
`define CFPM_CLK_MHZ       250
`define CFPM_SEC_NS        1000000000
`define CFPM_CLK_NS        4
`define CFPM_SEC_CYC       (`CFPM_SEC_NS / `CFPM_CLK_NS)
`endif

// ===== rtl/cfpm_pkg.sv
package cfpm_pkg;
   typedef enum logic [1:0] {
      CFPM_FV_DISABLED  = 2'h0,
      CFPM_FV_INTERLOCK = 2'h1,
      CFPM_FV_MAINTAIN  = 2'h2
   } cfpm_fmode_t;
   typedef enum logic [1:0] {
      CFPM_SCH_NONE  = 2'h0,
      CFPM_SCH_DAY   = 2'h1,
      CFPM_SCH_MONTH = 2'h2,
      CFPM_SCH_YEAR  = 2'h3
   } cfpm_sched_t;
   typedef enum logic [2:0] {
      CFPM_ST_OK      = 3'b001,
      CFPM_ST_REPRIME = 3'b010,
      CFPM_ST_LOCKED  = 3'b100
   } cfpm_fv_state_t;
endpackage

// ===== rtl/cfpm_pulse_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cfpm_pulse_if;
   logic pulse;
   logic [31:0] period;
   modport src (output pulse, output period);
   modport dst (input pulse, input period);
endinterface
`default_nettype wire

// ===== rtl/cfpm_pulse_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cfpm_pulse_sync (
   // Clock and reset
   input  wire logic   clk_i,
   input  wire logic   rst_i,
   // Raw pump line
   input  wire logic   pulse_i,
   // Edge events
   cfpm_pulse_if.src   ev
);
   logic        meta_r;
   logic        sync_r;
   logic        last_r;
   logic [31:0] gap_r;

   // Two-stage synchroniser; only sync_r feeds the edge detector
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         last_r <= 1'b0;
      end else begin
         meta_r <= pulse_i;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   assign ev.pulse = sync_r & ~last_r;

   // Cycles since previous edge, saturating, feeds the rate estimate
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gap_r     <= 32'h0000_0000;
         ev.period <= 32'h0000_0000;
      end else if (ev.pulse) begin
         ev.period <= gap_r;
         gap_r     <= 32'h0000_0001;
      end else if (gap_r != 32'hFFFF_FFFF) begin
         gap_r <= gap_r + 32'h0000_0001;
      end
   end
endmodule // cfpm_pulse_sync
`default_nettype wire

// ===== tb/cfpm_monitor_props.sv
`include "cfpm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cfpm_monitor_props (
   // Clock, reset, bus
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic        wb_ack_o,
   // Alarms and output control
   input wire logic        range_alarm_i,
   input wire logic        out_force_off_o,
   input wire logic        out_force_on_o,
   input wire logic        out_force_max_o,
   input wire logic [7:0]  out_max_pct_o,
   input wire logic        total_alarm_o,
   input wire logic        flow_alarm_o,
   input wire logic        monitor_active_o
);
   logic [31:0] ctrl_r;
   logic [31:0] rep_r;
   wire         take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   // Shadow copies; whole-word writes only, as the bench issues
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= `CFPM_CTRL_RST;
         rep_r  <= `CFPM_REPRIME_RST;
      end else if (take && wb_adr_i == `CFPM_CTRL_OFS) begin
         ctrl_r <= wb_dat_i;
      end else if (take && wb_adr_i == `CFPM_REPRIME_OFS) begin
         rep_r <= wb_dat_i;
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   property p_act;
      monitor_active_o == (total_alarm_o || flow_alarm_o || range_alarm_i);
   endproperty
   a_act: assert property (p_act) else $error("active flag");
   property p_tot_off;
      total_alarm_o && ctrl_r[0] |=> out_force_off_o;
   endproperty
   a_tot_off: assert property (p_tot_off) else $error("total off");
   property p_dis;
      $rose(flow_alarm_o) |-> $past(ctrl_r[2:1]) != 2'h0;
   endproperty
   a_dis: assert property (p_dis) else $error("alarm disabled");
   property p_rep_on;
      $rose(flow_alarm_o) && ctrl_r[6] && rep_r != 32'h0
         && !(total_alarm_o && ctrl_r[0]) |-> ##[0:2] out_force_on_o;
   endproperty
   a_rep_on: assert property (p_rep_on) else $error("no burst");
   property p_rep_end;
      $fell(flow_alarm_o) |-> ##[0:2] !out_force_on_o;
   endproperty
   a_rep_end: assert property (p_rep_end) else $error("burst on");
   property p_lock;
      (flow_alarm_o && ctrl_r[2:1] == 2'h1 && !out_force_on_o)[*3]
         |-> out_force_off_o;
   endproperty
   a_lock: assert property (p_lock) else $error("not held off");
   property p_excl;
      out_force_on_o |-> !out_force_off_o;
   endproperty
   a_excl: assert property (p_excl) else $error("on and off");
   property p_max;
      out_force_max_o |-> out_force_on_o && $past(ctrl_r[5]);
   endproperty
   a_max: assert property (p_max) else $error("max misuse");
   property p_pct;
      $stable(ctrl_r) |-> out_max_pct_o == ctrl_r[15:8];
   endproperty
   a_pct: assert property (p_pct) else $error("max pct");
endmodule // cfpm_monitor_props
bind cfpm_monitor cfpm_monitor_props u_props (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
   .wb_ack_o, .range_alarm_i, .out_force_off_o, .out_force_on_o,
   .out_force_max_o, .out_max_pct_o, .total_alarm_o, .flow_alarm_o,
   .monitor_active_o);
`default_nettype wire

// ===== tb/cfpm_monitor_tb_top.sv
`include "cfpm_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) chk(n, e, g)
`define WAITK(c, lim) \
   k = 0; \
   while (!(c) && k < lim) begin \
      @(posedge clk_i); \
      k++; \
   end
module cfpm_monitor_tb_top;
   logic        clk_i = 1'b0, rst_i = 1'b1, pulse_i, go = 1'b0, busy;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00, out_pct_i = 8'h00, out_max_pct_o;
   logic [3:0]  wb_sel_i = 4'hF, cnt = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, v, ld;
   logic        wb_ack_o, out_on_i = 1'b0, out_manual_i = 1'b0;
   logic        range_alarm_i = 1'b0, total_alarm_o, flow_alarm_o;
   logic        out_force_off_o, out_force_on_o, out_force_max_o;
   logic        monitor_active_o;
   int          fail_count = 0, cmp_count = 0, seed = 32'hDA6C207C;
   int          i, s, b, k, n;
   logic [31:0] rv [9] = '{32'h6402, 32'h8, 32'h1, 32'hFFFF_FFFF,
                           32'h100, 32'h3, 32'h5, 32'h0, 32'hA};
   always #2 clk_i = ~clk_i;
   // Short second so the alarm timers finish in a few hundred cycles
   cfpm_monitor #(.SEC_CYC(20)) dut (
      .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pulse_i, .out_on_i,
      .out_pct_i, .out_manual_i, .out_force_off_o, .out_force_on_o,
      .out_force_max_o, .out_max_pct_o, .range_alarm_i,
      .total_alarm_o, .flow_alarm_o, .monitor_active_o);
   cfpm_pump_model pump (.clk_i, .go_i(go), .cnt_i(cnt),
      .pulse_o(pulse_i), .busy_o(busy));
   // ********
   // Tasks
   // ********
   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s exp %0h got %0h", nm, e, g);
      end
   endtask
   // Pump model pulses every 4 cycles against a 20-cycle second
   function automatic logic [31:0] rate_exp(input logic [31:0] vol, s, old);
      return (old * s + (vol * 32'd20 / 32'd4) * (32'd100 - s)) / 32'd100;
   endfunction
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int t;
      t = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         t++;
      end while (wb_ack_o !== 1'b1 && t < 40);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (t >= 40) `CHK("ack", 1'b1, 1'b0);
      @(posedge clk_i);
   endtask
   task automatic pulses(input logic [3:0] c);
      go  <= 1'b1;
      cnt <= c;
      @(posedge clk_i);
      go <= 1'b0;
      @(posedge clk_i);
      `WAITK(busy === 1'b0, 99)
      repeat (6) @(posedge clk_i);
   endtask
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ********
   // Scenarios
   // ********
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (i = 0; i < 9; i++) begin
         bus(1'b0, 8'(i * 4), 32'h0);
         `CHK("reset value", rv[i], q);
      end
      bus(1'b1, 8'h3C, 32'hFFFF_FFFF);
      bus(1'b0, 8'h3C, 32'h0);
      `CHK("unmapped", 32'h0, q);
      `CHK("max pct", 32'h64, 32'(out_max_pct_o));
      v = 32'(($random(seed) & 32'hFF) + 1);
      n = ($random(seed) & 7) + 2;
      bus(1'b1, `CFPM_VOLPP_OFS, v);
      bus(1'b1, `CFPM_SMOOTH_OFS, 32'h0);
      pulses(4'(n));
      bus(1'b0, `CFPM_TOTAL_OFS, 32'h0);
      `CHK("total", v * n, q);
      bus(1'b0, `CFPM_RATE_OFS, 32'h0);
      `CHK("rate", rate_exp(v, 32'h0, 32'h0), q);
      bus(1'b1, `CFPM_TSET_OFS, v * n);
      `CHK("below set point", 1'b0, total_alarm_o);
      bus(1'b1, `CFPM_SMOOTH_OFS, 32'h64);
      pulses(4'h1);
      `CHK("total alarm", 1'b1, total_alarm_o);
      `CHK("active", 1'b1, monitor_active_o);
      bus(1'b0, `CFPM_RATE_OFS, 32'h0);
      `CHK("smoothed", rate_exp(v, 32'h64, rate_exp(v, 0, 0)), q);
      bus(1'b1, `CFPM_CTRL_OFS, 32'h6403);
      `CHK("total off", 1'b1, out_force_off_o);
      bus(1'b1, `CFPM_CTRL_OFS, 32'h6402);
      `CHK("keep running", 1'b0, out_force_off_o);
      bus(1'b1, `CFPM_TSET_OFS, 32'hFFFF_FFFF);
      range_alarm_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      `CHK("range active", 1'b1, monitor_active_o);
      range_alarm_i <= 1'b0;
      v = $random(seed);
      bus(1'b1, `CFPM_NOW_OFS, v);
      bus(1'b1, `CFPM_CMD_OFS, 32'h1);
      bus(1'b0, `CFPM_TOTAL_OFS, 32'h0);
      `CHK("total reset", 32'h0, q);
      bus(1'b0, `CFPM_STAMP_OFS, 32'h0);
      `CHK("stamp", v, q);
      ld = $random(seed) | 32'h1;
      bus(1'b1, `CFPM_LOADVAL_OFS, ld);
      for (s = 1; s < 4; s++) begin
         bus(1'b1, `CFPM_CTRL_OFS, 32'h6402 | (s << 3));
         for (b = 2; b < 5; b++) begin
            bus(1'b1, `CFPM_CMD_OFS, 32'h2);
            bus(1'b1, `CFPM_CMD_OFS, 32'h1 << b);
            bus(1'b0, `CFPM_TOTAL_OFS, 32'h0);
            `CHK("schedule", (b == s + 1) ? 32'h0 : ld, q);
         end
      end
      bus(1'b1, `CFPM_DELAY_OFS, 32'h2);
      bus(1'b1, `CFPM_REPRIME_OFS, 32'h1);
      bus(1'b1, `CFPM_CTRL_OFS, 32'h6442);
      out_on_i <= 1'b1;
      `WAITK(flow_alarm_o === 1'b1, 200)
      `CHK("flow alarm", 1'b1, flow_alarm_o === 1'b1 && k <= 65);
      repeat (3) @(posedge clk_i);
      `CHK("reprime", 1'b1, out_force_on_o);
      `WAITK(out_force_on_o === 1'b0, 60)
      repeat (3) @(posedge clk_i);
      `CHK("locked", 1'b1, out_force_off_o);
      repeat (100) @(posedge clk_i);
      `CHK("still locked", 1'b1, out_force_off_o & flow_alarm_o);
      out_manual_i <= 1'b1;
      pulses(4'h2);
      repeat (60) @(posedge clk_i);
      pulses(4'h2);
      `CHK("count wiped", 1'b1, flow_alarm_o);
      pulses(4'h1);
      `CHK("cleared", 1'b0, flow_alarm_o);
      out_manual_i <= 1'b0;
      bus(1'b1, `CFPM_REPRIME_OFS, 32'h5);
      bus(1'b1, `CFPM_CTRL_OFS, 32'h6462);
      out_on_i  <= 1'b0;
      out_pct_i <= 8'h32;
      `WAITK(flow_alarm_o === 1'b1, 200)
      `CHK("pct alarm", 1'b1, flow_alarm_o);
      repeat (3) @(posedge clk_i);
      `CHK("burst at max", 1'b1, out_force_max_o);
      pulses(4'h3);
      `CHK("burst ended", 2'b00, {flow_alarm_o, out_force_on_o});
      bus(1'b1, `CFPM_CTRL_OFS, 32'h6425);
      `WAITK(flow_alarm_o === 1'b1, 200)
      repeat (2) @(posedge clk_i);
      `CHK("maintain", 2'b10, {flow_alarm_o, out_force_off_o});
      bus(1'b1, `CFPM_TSET_OFS, 32'h0);
      `CHK("either off", 1'b1, out_force_off_o);
      bus(1'b1, `CFPM_CTRL_OFS, 32'h6424);
      `CHK("both keep", 2'b10, {total_alarm_o, out_force_off_o});
      bus(1'b1, `CFPM_TSET_OFS, 32'hFFFF_FFFF);
      for (i = 0; i < 2; i++) begin
         bus(1'b1, `CFPM_CTRL_OFS, (i == 0) ? 32'h6400 : 32'h6422);
         out_on_i  <= 1'b1;
         out_pct_i <= 8'(($random(seed) & 32'h7FFF_FFFF) % 6);
         repeat (150) @(posedge clk_i);
         `CHK("no flow alarm", 1'b0, flow_alarm_o);
      end
      close_out();
   end
   // Watchdog at about twenty times the expected run length
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      close_out();
   end
endmodule // cfpm_monitor_tb_top
`default_nettype wire

// ===== tb/cfpm_pump_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Pump pulse source: a burst of cnt_i pulses per go_i
// ********
module cfpm_pump_model (
   // Clock
   input  wire logic       clk_i,
   // Burst request
   input  wire logic       go_i,
   input  wire logic [3:0] cnt_i,
   // Pump side
   output logic            pulse_o,
   output logic            busy_o
);
   logic [3:0] left_r = 4'h0;
   logic [1:0] ph_r   = 2'h0;
   always @(posedge clk_i) begin
      if (go_i && left_r == 4'h0) begin
         left_r <= cnt_i;
         ph_r   <= 2'h0;
      end else if (left_r != 4'h0) begin
         ph_r <= ph_r + 2'h1;
         if (ph_r == 2'h3) begin
            left_r <= left_r - 4'h1;
         end
      end
   end
   // Two cycles high, two low, so the synchroniser never misses one
   assign pulse_o = (left_r != 4'h0) && !ph_r[1];
   assign busy_o  = left_r != 4'h0;
endmodule // cfpm_pump_model
`default_nettype wire
